// ---- rip_pkg.sv ----
// constants and types shared by the line power controller and its bench
package rip_pkg;

  localparam int CH_N = 2;
  localparam int FIFO_DEPTH = 8;
  localparam int IDLE_W = 33;
  localparam int WAKE_W = 15;

  // clock rate and required times
  localparam longint unsigned CLK_FREQ_HZ = 64'd200_000_000;
  localparam longint unsigned IDLE_TIME_S = 64'd30;
  localparam longint unsigned WAKE_TIME_US = 64'd100;
  localparam longint unsigned US_PER_S = 64'd1_000_000;

  // derived cycle counts; wake time rounds up
  localparam logic [IDLE_W-1:0] IDLE_CYCLES_DFLT = IDLE_W'(IDLE_TIME_S * CLK_FREQ_HZ);
  localparam logic [WAKE_W-1:0] WAKE_CYCLES_DFLT =
    WAKE_W'((WAKE_TIME_US * CLK_FREQ_HZ + US_PER_S - 64'd1) / US_PER_S);

  // reset values
  localparam logic [CH_N-1:0] TX_IDLE_RST = 2'h0;
  localparam logic [CH_N-1:0] DRV_RST = 2'h3;

  typedef enum logic [2:0] {
    RIP_OFF  = 3'h1,
    RIP_WAKE = 3'h2,
    RIP_RUN  = 3'h4
  } rip_mode_t;

  typedef struct packed {
    rip_mode_t mode;
    logic [IDLE_W-1:0] idle_cnt;
    logic [WAKE_W-1:0] wake_cnt;
    logic [CH_N-1:0] tx_prev;
    logic [CH_N-1:0] rx_prev;
    logic [CH_N-1:0] last_push;
    logic [CH_N-1:0] drv;
    logic [CH_N-1:0] rx_out;
    logic valid_level;
  } rip_state_t;

endpackage : rip_pkg

// ---- rip_fifo_if.sv ----
// push and pop handshake between the controller and its transmit fifo
`timescale 1ns/10ps
`default_nettype none
interface rip_fifo_if #(parameter int W = 2);
  logic push_valid;
  logic push_ready;
  logic [W-1:0] push_data;
  logic pop_valid;
  logic pop_ready;
  logic [W-1:0] pop_data;

  modport fifo (
    input push_valid, push_data, pop_ready,
    output push_ready, pop_valid, pop_data
  );
  modport user (
    output push_valid, push_data, pop_ready,
    input push_ready, pop_valid, pop_data
  );
endinterface : rip_fifo_if
`default_nettype wire

// ---- rip_fifo.sv ----
// small synchronous fifo holding transmit levels
`timescale 1ns/10ps
`default_nettype none
module rip_fifo #(
  parameter int W = 2,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // handshake
  rip_fifo_if.fifo port_if
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] rd_ptr;
    logic [AW-1:0] wr_ptr;
    logic [AW:0] count;
  } rip_fifo_state_t;

  rip_fifo_state_t st_reg;
  rip_fifo_state_t st_next;
  logic do_push;
  logic do_pop;

  assign port_if.push_ready = (st_reg.count != (AW+1)'(DEPTH));
  assign port_if.pop_valid = (st_reg.count != '0);
  assign port_if.pop_data = st_reg.mem[st_reg.rd_ptr];
  assign do_push = port_if.push_valid && port_if.push_ready;
  assign do_pop = port_if.pop_valid && port_if.pop_ready;

  always_comb
  begin
    st_next = st_reg;
    if (do_push)
    begin
      st_next.mem[st_reg.wr_ptr] = port_if.push_data;
      st_next.wr_ptr = (st_reg.wr_ptr == AW'(DEPTH - 1)) ? '0 : st_reg.wr_ptr + 1'b1;
    end
    if (do_pop)
    begin
      st_next.rd_ptr = (st_reg.rd_ptr == AW'(DEPTH - 1)) ? '0 : st_reg.rd_ptr + 1'b1;
    end
    if (do_push && !do_pop)
    begin
      st_next.count = st_reg.count + 1'b1;
    end
    else if (do_pop && !do_push)
    begin
      st_next.count = st_reg.count - 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  fifo_bound_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    st_reg.count <= (AW+1)'(DEPTH))
    else $error("fifo count above depth");

endmodule : rip_fifo
`default_nettype wire

// ---- rip_power_ctrl.sv ----
// line transceiver control: idle shutdown, forced modes, wake delay, level flag
//
// Contract
// - low shutdown input forces charge pump and drivers off
// - force-active keeps running when not forced off
// - auto mode: off after 30 s idle
// - drivers high impedance whenever shut down
// - any edge wakes from automatic shutdown
// - receiver outputs inverted, always active
// - drivers send inverse of transmit input
// - flag low without valid receiver level
// - flag depends only on receiver levels
// - force-active tied to flag: level or edges
// - both forces tied to flag: level only
// - drivers return after 100 us wake delay
`timescale 1ns/10ps
`default_nettype none
module rip_power_ctrl #(
  parameter logic [rip_pkg::IDLE_W-1:0] IDLE_CYCLES = rip_pkg::IDLE_CYCLES_DFLT,
  parameter logic [rip_pkg::WAKE_W-1:0] WAKE_CYCLES = rip_pkg::WAKE_CYCLES_DFLT
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // mode controls
  input wire logic force_active_in,
  input wire logic force_shutdown_n_in,
  // logic side transmit inputs and back-pressure
  input wire logic tx_logic_in,
  input wire logic tx_logic_in_b,
  output logic tx_ready_out,
  // logic side receiver outputs and level flag
  output logic rx_logic_out,
  output logic rx_logic_out_b,
  output logic no_valid_level_n_out,
  // line side receiver levels and level detectors
  input wire logic line_receiver_in,
  input wire logic line_receiver_in_b,
  input wire logic [rip_pkg::CH_N-1:0] rx_level_valid_in,
  // line side drivers, enable low while driving
  output logic line_driver_out,
  output logic line_driver_out_b,
  output logic [rip_pkg::CH_N-1:0] line_driver_oe_n_out,
  // power status
  output logic charge_pump_en_out,
  output logic tx_enabled_out
);
  import rip_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // state and per-channel edge detection

  localparam rip_state_t ST_RST = '{
    mode: RIP_WAKE,
    idle_cnt: '0,
    wake_cnt: '0,
    tx_prev: TX_IDLE_RST,
    rx_prev: '0,
    last_push: TX_IDLE_RST,
    drv: DRV_RST,
    rx_out: '1,
    valid_level: 1'b0
  };

  rip_state_t st_reg;
  rip_state_t st_next;
  logic [CH_N-1:0] tx_now;
  logic [CH_N-1:0] rx_now;
  logic [CH_N-1:0] ch_edge;
  logic any_edge;
  logic idle_expired;
  logic shutdown_req;

  assign tx_now = {tx_logic_in_b, tx_logic_in};
  assign rx_now = {line_receiver_in_b, line_receiver_in};

  genvar gi;
  generate
    for (gi = 0; gi < CH_N; gi++)
    begin : g_edge
      assign ch_edge[gi] = (tx_now[gi] ^ st_reg.tx_prev[gi]) |
        (rx_now[gi] ^ st_reg.rx_prev[gi]);
    end
  endgenerate

  assign any_edge = |ch_edge;
  // an edge in this cycle already cancels expiry
  assign idle_expired = (st_reg.idle_cnt == IDLE_CYCLES) && !any_edge;
  // forced off wins; forced on masks idle expiry
  assign shutdown_req = !force_shutdown_n_in ||
    (!force_active_in && idle_expired);

  ////////////////////////////////////////////////////////////////////////////
  // transmit fifo: drained only while drivers are enabled

  rip_fifo_if #(.W(CH_N)) tx_if ();

  assign tx_if.push_valid = (tx_now != st_reg.last_push);
  assign tx_if.push_data = tx_now;
  assign tx_if.pop_ready = (st_reg.mode == RIP_RUN);
  assign tx_ready_out = tx_if.push_ready;

  rip_fifo #(
    .W(CH_N),
    .DEPTH(FIFO_DEPTH)
  ) u_tx_fifo (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .port_if(tx_if)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    st_next = st_reg;
    st_next.tx_prev = tx_now;
    st_next.rx_prev = rx_now;
    st_next.rx_out = ~rx_now;
    st_next.valid_level = |rx_level_valid_in;
    if (tx_if.push_valid && tx_if.push_ready)
    begin
      st_next.last_push = tx_now;
    end
    if (tx_if.pop_valid && tx_if.pop_ready)
    begin
      st_next.drv = ~tx_if.pop_data;
    end
    // free-running saturating idle timer
    if (any_edge)
    begin
      st_next.idle_cnt = '0;
    end
    else if (st_reg.idle_cnt != IDLE_CYCLES)
    begin
      st_next.idle_cnt = st_reg.idle_cnt + 1'b1;
    end
    unique case (st_reg.mode)
      RIP_OFF:
      begin
        st_next.wake_cnt = '0;
        if (!shutdown_req)
        begin
          st_next.mode = RIP_WAKE;
        end
      end
      RIP_WAKE:
      begin
        if (shutdown_req)
        begin
          st_next.mode = RIP_OFF;
        end
        else if (st_reg.wake_cnt == WAKE_CYCLES - 1'b1)
        begin
          st_next.mode = RIP_RUN;
        end
        else
        begin
          st_next.wake_cnt = st_reg.wake_cnt + 1'b1;
        end
      end
      RIP_RUN:
      begin
        st_next.wake_cnt = '0;
        if (shutdown_req)
        begin
          st_next.mode = RIP_OFF;
        end
      end
      default:
      begin
        st_next.mode = RIP_OFF;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      st_reg <= ST_RST;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign rx_logic_out = st_reg.rx_out[0];
  assign rx_logic_out_b = st_reg.rx_out[1];
  assign no_valid_level_n_out = st_reg.valid_level;
  assign line_driver_out = st_reg.drv[0];
  assign line_driver_out_b = st_reg.drv[1];
  assign line_driver_oe_n_out = {CH_N{st_reg.mode != RIP_RUN}};
  assign charge_pump_en_out = (st_reg.mode != RIP_OFF);
  assign tx_enabled_out = (st_reg.mode == RIP_RUN);

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rst_n_in);

  forced_off_a: assert property (
    !force_shutdown_n_in |=> (st_reg.mode == RIP_OFF) && !charge_pump_en_out)
    else $error("forced off did not shut down");

  forced_on_a: assert property (
    force_shutdown_n_in && force_active_in && tx_enabled_out |=> tx_enabled_out)
    else $error("forced on left run");

  idle_off_a: assert property (
    force_shutdown_n_in && !force_active_in && (st_reg.idle_cnt == IDLE_CYCLES) &&
    !any_edge && (st_reg.mode != RIP_OFF) |=> (st_reg.mode == RIP_OFF))
    else $error("idle expiry did not shut down");

  driver_hiz_a: assert property (
    !tx_enabled_out |-> (line_driver_oe_n_out == {CH_N{1'b1}}))
    else $error("driver enabled while shut down");

  edge_wake_a: assert property (
    (st_reg.mode == RIP_OFF) && any_edge && force_shutdown_n_in |=>
    (st_reg.mode == RIP_WAKE))
    else $error("edge did not wake");

  rx_invert_a: assert property (
    1'b1 |=> (rx_logic_out == !$past(line_receiver_in)) &&
    (rx_logic_out_b == !$past(line_receiver_in_b)))
    else $error("receiver output not inverse");

  drv_invert_a: assert property (
    tx_if.pop_valid && tx_enabled_out |=>
    ({line_driver_out_b, line_driver_out} == ~$past(tx_if.pop_data)))
    else $error("driver not inverse of transmit data");

  level_flag_a: assert property (
    1'b1 |=> (no_valid_level_n_out == $past(|rx_level_valid_in)))
    else $error("level flag wrong");

  timer_restart_a: assert property (
    any_edge |=> (st_reg.idle_cnt == '0))
    else $error("idle timer not restarted");

  wake_delay_a: assert property (
    $rose(tx_enabled_out) |-> ($past(st_reg.mode) == RIP_WAKE) &&
    ($past(st_reg.wake_cnt) == WAKE_CYCLES - 1'b1))
    else $error("drivers enabled before wake delay");

  rx_always_a: assert property (
    (st_reg.mode == RIP_OFF) ##1 1'b1 |-> (rx_logic_out == !$past(line_receiver_in)))
    else $error("receiver idle during shutdown");

  wake_hold_a: assert property (
    (st_reg.mode == RIP_WAKE) |-> charge_pump_en_out && !tx_enabled_out)
    else $error("drivers enabled during wake");

  wake_count_a: assert property (
    (st_reg.mode == RIP_WAKE) && !shutdown_req &&
    (st_reg.wake_cnt != WAKE_CYCLES - 1'b1) |=>
    (st_reg.mode == RIP_WAKE) && (st_reg.wake_cnt == $past(st_reg.wake_cnt) + 1'b1))
    else $error("wake delay not counting");

  idle_run_a: assert property (
    force_shutdown_n_in && !force_active_in && (st_reg.mode == RIP_RUN) &&
    (st_reg.idle_cnt != IDLE_CYCLES) |=> (st_reg.mode == RIP_RUN))
    else $error("shut down before idle time");

  forced_wake_a: assert property (
    (st_reg.mode == RIP_OFF) && force_shutdown_n_in && force_active_in |=>
    (st_reg.mode == RIP_WAKE))
    else $error("forced on did not wake");

  edge_keeps_a: assert property (
    any_edge && force_shutdown_n_in |=> (st_reg.mode != RIP_OFF))
    else $error("shut down despite edge");

  timer_count_a: assert property (
    !any_edge && (st_reg.idle_cnt != IDLE_CYCLES) |=>
    (st_reg.idle_cnt == $past(st_reg.idle_cnt) + 1'b1))
    else $error("idle timer not counting");

  timer_sat_a: assert property (
    !any_edge && (st_reg.idle_cnt == IDLE_CYCLES) |=> (st_reg.idle_cnt == IDLE_CYCLES))
    else $error("idle timer left saturation");

  flag_forced_a: assert property (
    (!force_shutdown_n_in || force_active_in) |=>
    (no_valid_level_n_out == $past(|rx_level_valid_in)))
    else $error("level flag tied to force inputs");

  pump_off_hiz_a: assert property (
    !charge_pump_en_out |-> (line_driver_oe_n_out == {CH_N{1'b1}}) && !tx_enabled_out)
    else $error("driver enabled with pump off");

  drv_hold_a: assert property (
    !(tx_if.pop_valid && tx_if.pop_ready) |=> $stable({line_driver_out_b, line_driver_out}))
    else $error("driver data changed without pop");

  rx_off_b_a: assert property (
    (st_reg.mode == RIP_OFF) |=> (rx_logic_out_b == !$past(line_receiver_in_b)))
    else $error("receiver b idle during shutdown");

endmodule : rip_power_ctrl
`default_nettype wire

// ---- rip_far_model.sv ----
// remote line transceiver model facing the device's line side
`timescale 1ns/10ps
`default_nettype none
module rip_far_model (
  // clock
  input wire logic clk_sys_in,
  // bench controls
  input wire logic connected_in,
  input wire logic [1:0] send_in,
  // device line drivers
  input wire logic [1:0] drv_in,
  input wire logic [1:0] oe_n_in,
  // towards the device and the bench
  output logic [1:0] rx_line_out,
  output logic [1:0] valid_out,
  output logic [1:0] wire_out
);
  logic [1:0] last_reg = 2'h0;

  always_ff @(posedge clk_sys_in)
  begin
    for (int i = 0; i < 2; i++)
    begin
      if (!oe_n_in[i])
      begin
        last_reg[i] <= drv_in[i];
      end
    end
  end

  // released line has no pull, so it shows the inverse of its last level
  always_comb
  begin
    for (int i = 0; i < 2; i++)
    begin
      wire_out[i] = oe_n_in[i] ? ~last_reg[i] : drv_in[i];
    end
  end

  assign rx_line_out = send_in;
  assign valid_out = {2{connected_in}};
endmodule : rip_far_model
`default_nettype wire

// ---- rip_power_ctrl_tb.sv ----
// self-checking bench for the line power controller
`timescale 1ns/10ps
`default_nettype none
module rip_power_ctrl_tb;
  import rip_pkg::*;
  localparam int IDLE = 16;
  localparam int WAKE = 4;
  logic clk_sys_in = 1'b0;
  logic rst_n = 1'b0;
  logic fa = 1'b0;
  logic fs_n = 1'b1;
  logic wired = 1'b0;
  logic wired_fa = 1'b0;
  logic connected = 1'b1;
  logic [1:0] tx = 2'h0;
  logic [1:0] send = 2'h0;
  logic tx_ready, flag, cp, ten;
  logic [1:0] rx_out, drv, oe_n, rxl, val, seen;
  int n_errors = 0;
  int checked = 0;

  rip_power_ctrl #(.IDLE_CYCLES(IDLE_W'(IDLE)), .WAKE_CYCLES(WAKE_W'(WAKE))) i_dut (
    .clk_sys_in(clk_sys_in), .rst_n_in(rst_n),
    .force_active_in(wired_fa ? flag : fa), .force_shutdown_n_in(wired ? flag : fs_n),
    .tx_logic_in(tx[0]), .tx_logic_in_b(tx[1]), .tx_ready_out(tx_ready),
    .rx_logic_out(rx_out[0]), .rx_logic_out_b(rx_out[1]), .no_valid_level_n_out(flag),
    .line_receiver_in(rxl[0]), .line_receiver_in_b(rxl[1]), .rx_level_valid_in(val),
    .line_driver_out(drv[0]), .line_driver_out_b(drv[1]), .line_driver_oe_n_out(oe_n),
    .charge_pump_en_out(cp), .tx_enabled_out(ten));

  rip_far_model i_far (.clk_sys_in(clk_sys_in), .connected_in(connected), .send_in(send),
    .drv_in(drv), .oe_n_in(oe_n), .rx_line_out(rxl), .valid_out(val), .wire_out(seen));

  initial
  begin
    forever #2.5 clk_sys_in = ~clk_sys_in;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask : step

  task automatic chk(input string what, input logic [31:0] seen_v, input logic [31:0] exp_v);
    checked++;
    if (seen_v !== exp_v)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp_v, seen_v);
    end
  endtask : chk

  task automatic wait_run;
    int n;
    n = 0;
    while (ten !== 1'b1 && n < 50)
    begin
      chk("oe_n in wake", oe_n, 2'h3);
      step(1);
      n++;
    end
    chk("wake delay", 32'(n >= WAKE - 1 && n <= WAKE + 2), 1);
    chk("oe_n running", oe_n, 2'h0);
  endtask : wait_run

  task automatic wait_drv(input int lim);
    int n;
    n = 0;
    while ((drv ^ tx) !== 2'h3 && n < lim)
    begin
      step(1);
      n++;
    end
    chk("driver data", drv ^ tx, 2'h3);
    chk("line wire", seen ^ tx, 2'h3);
  endtask : wait_drv

  task automatic close_out;
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
    begin
      $display("TEST PASSED");
    end
    else
    begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : close_out

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    step(5);
    chk("reset oe_n", oe_n, 2'h3);
    chk("reset tx enable", ten, 1'b0);
    rst_n = 1'b1;
    wait_run();
    $display("test reset done");
  endtask : t_reset

  task automatic t_tx;
    for (int v = 1; v < 5; v++)
    begin
      tx = 2'(v);
      wait_drv(4);
    end
    $display("test transmit done");
  endtask : t_tx

  task automatic t_forced_off;
    fs_n = 1'b0;
    fa = 1'b1;
    step(1);
    chk("pump forced off", cp, 1'b0);
    chk("oe_n forced off", oe_n, 2'h3);
    for (int v = 1; v < 5; v++)
    begin
      send = 2'(v);
      step(1);
      chk("rx inverse", rx_out ^ send, 2'h3);
    end
    connected = 1'b0;
    step(1);
    chk("flag no level", flag, 1'b0);
    connected = 1'b1;
    step(1);
    chk("flag level", flag, 1'b1);
    fs_n = 1'b1;
    step(1);
    chk("pump waking", cp, 1'b1);
    wait_run();
    step(IDLE + 6);
    chk("forced on holds", ten, 1'b1);
    fa = 1'b0;
    $display("test forced modes done");
  endtask : t_forced_off

  task automatic t_idle;
    send[0] = ~send[0];
    step(IDLE - 4);
    send[1] = ~send[1];
    step(IDLE - 4);
    chk("timer restart", ten, 1'b1);
    step(8);
    chk("idle pump off", cp, 1'b0);
    chk("idle oe_n", oe_n, 2'h3);
    send[0] = ~send[0];
    step(1);
    chk("edge wakes", cp, 1'b1);
    wait_run();
    $display("test idle done");
  endtask : t_idle

  task automatic t_fifo;
    int n;
    n = 0;
    fs_n = 1'b0;
    step(2);
    repeat (12)
    begin
      if (tx_ready === 1'b1)
      begin
        tx[0] = ~tx[0];
        n++;
      end
      step(1);
    end
    chk("fifo pushes", n, FIFO_DEPTH);
    chk("fifo full", tx_ready, 1'b0);
    tx[1] = ~tx[1];
    fs_n = 1'b1;
    step(1);
    wait_run();
    wait_drv(20);
    chk("fifo drained", tx_ready, 1'b1);
    $display("test fifo done");
  endtask : t_fifo

  task automatic t_wired_on;
    wired_fa = 1'b1;
    connected = 1'b0;
    send[0] = ~send[0];
    step(2);
    chk("edge keeps running", ten, 1'b1);
    step(IDLE + 2);
    chk("no level no edge off", cp, 1'b0);
    connected = 1'b1;
    step(2);
    chk("level wakes", cp, 1'b1);
    wait_run();
    step(IDLE + 4);
    chk("level holds run", ten, 1'b1);
    $display("test force-active wired done");
  endtask : t_wired_on

  task automatic t_wired;
    wired = 1'b1;
    connected = 1'b0;
    step(3);
    chk("wired off", cp, 1'b0);
    send[0] = ~send[0];
    step(2);
    chk("wired ignores edge", cp, 1'b0);
    connected = 1'b1;
    step(2);
    chk("wired wake", cp, 1'b1);
    wait_run();
    wired = 1'b0;
    wired_fa = 1'b0;
    $display("test wired done");
  endtask : t_wired

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    t_reset();
    t_tx();
    t_forced_off();
    t_idle();
    t_fifo();
    t_wired_on();
    t_wired();
    close_out();
  end

  initial
  begin
    step(5000);
    n_errors++;
    close_out();
  end
endmodule : rip_power_ctrl_tb
`default_nettype wire
